// ---- src/acsf_pkg.sv ----
/*
 * acsf_pkg: constants and types shared by the alert sample filter block.
 * Assumes a 40 MHz aclk and word-aligned AXI4-Lite register access.
 */
package acsf_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_OC_COUNT  = 8'h44;
    localparam logic [7:0] IDX_UC_COUNT  = 8'h45;
    localparam logic [7:0] IDX_OP_COUNT  = 8'h46;
    localparam logic [7:0] IDX_HV_COUNT  = 8'h47;
    localparam logic [7:0] IDX_ENABLE    = 8'h49;
    localparam logic [7:0] IDX_REFRESH   = 8'h50;
    localparam logic [7:0] IDX_STATUS    = 8'h51;
    localparam logic [7:0] IDX_MASK      = 8'h52;
    localparam int         ADDR_W        = 10;
    localparam int         IDX_LSB       = 2;

    localparam logic [7:0]  COUNT_RESET  = 8'h00;
    localparam logic [23:0] ENABLE_RESET = 24'h000000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET   = 16'h0000;

    // enable register field positions, channel 1 in the msb of each nibble
    localparam int EN_OC_LSB = 20;
    localparam int EN_UC_LSB = 16;
    localparam int EN_HV_LSB = 12;
    localparam int EN_OP_LSB = 4;

    localparam int NUM_CH    = 4;
    localparam int NUM_KIND  = 4;
    localparam int FIELD_W   = 2;
    localparam int CNT_W     = 5;

    localparam logic [1:0] CODE_1  = 2'h0;
    localparam logic [1:0] CODE_4  = 2'h1;
    localparam logic [1:0] CODE_8  = 2'h2;
    localparam logic [4:0] SAMPLES_1  = 5'h01;
    localparam logic [4:0] SAMPLES_4  = 5'h04;
    localparam logic [4:0] SAMPLES_8  = 5'h08;
    localparam logic [4:0] SAMPLES_16 = 5'h10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // limit comparator results, channel 1 in bit 3
    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] undercurrent;
        logic [3:0] overpower;
        logic [3:0] high_voltage;
    } acsf_exceed_s;

    function automatic logic [4:0] acsf_target(input logic [1:0] code);
        case (code)
            CODE_1:  acsf_target = SAMPLES_1;
            CODE_4:  acsf_target = SAMPLES_4;
            CODE_8:  acsf_target = SAMPLES_8;
            default: acsf_target = SAMPLES_16;
        endcase
    endfunction : acsf_target
endpackage : acsf_pkg

// ---- src/acsf_qualify.sv ----
/*
 * acsf_qualify: consecutive-sample counter for one channel and one limit.
 * Assumes sample is a one-cycle conversion-complete pulse on aclk.
 */
`timescale 1ns/1ps
module acsf_qualify (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic       sample,
    input  wire logic       exceed,
    input  wire logic [1:0] code,
    output logic            qualified
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic       next_qualified;
    logic [4:0] target;

    always_comb begin
        target         = acsf_pkg::acsf_target(code);
        next_count     = count;
        next_qualified = qualified;
        if (sample) begin
            if (exceed) begin
                if (count < target) begin
                    next_count = count + 5'h01;
                end
                next_qualified = (next_count >= target);
            end else begin
                // one clean conversion drops the alert at once
                next_count     = 5'h00;
                next_qualified = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count     <= 5'h00;
            qualified <= 1'b0;
        end else if (ce) begin
            count     <= next_count;
            qualified <= next_qualified;
        end
    end

    count_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && !sample) |=> $stable(count) && $stable(qualified))
        else $error("count moved without a conversion");
    miss_clears_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && sample && !exceed) |=> (count == 5'h00) && !qualified)
        else $error("clean sample did not clear the run");
    qual_needs_run_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(qualified) |-> (count == target) && $past(exceed))
        else $error("alert raised before the full run");
endmodule : acsf_qualify

// ---- src/acsf_irq.sv ----
/*
 * acsf_irq: sticky write-one-to-clear event status, mask and interrupt.
 * Assumes set and clr are one-cycle pulses from the same aclk domain.
 */
`timescale 1ns/1ps
module acsf_irq (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [15:0] set,
    input  wire logic [15:0] clr,
    input  wire logic [15:0] mask,
    output logic      [15:0] status,
    output logic             irq
);
    logic [15:0] next_status;
    logic        next_irq;

    always_comb begin
        // a set landing with its clear is kept
        next_status = (status & ~clr) | set;
        next_irq    = |(next_status & mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= acsf_pkg::STATUS_RESET;
            irq    <= 1'b0;
        end else if (ce) begin
            status <= next_status;
            irq    <= next_irq;
        end
    end

    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && |set) |=> ((status & $past(set)) == $past(set)))
        else $error("event lost against a clear");
endmodule : acsf_irq

// ---- src/acsf_top.sv ----
/*
 * acsf_top: alert consecutive-sample filter with AXI4-Lite registers.
 * Assumes limit comparators drive exceed, valid when conv_done pulses.
 */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// Functional notes
// - undercurrent alert rises only after the programmed run of samples.
// - overpower alert rises only after the programmed run of samples.
// - high-voltage alert rises only after the programmed run of samples.
// - field codes 0,1,2,3 demand 1, 4, 8 and 16 consecutive samples.
// - every count field resets to code 0, one sample qualifies.
// - overcurrent fields: ch2 bits 5-4, ch3 bits 3-2, ch4 bits 1-0.
// - undercurrent fields: ch1 7-6, ch2 5-4, ch3 3-2, ch4 1-0.
// - overpower fields: ch1 7-6, ch2 5-4, ch3 3-2, ch4 1-0.
// - high-voltage fields: ch1 7-6, ch2 5-4, ch3 3-2, ch4 1-0.
// - a channel counter saturates at its target until a conversion shows no excess.
// - one clean conversion after the alert clears it.
// - a qualified alert reaches its pin only when enabled.
// - written enables act only after a refresh command.
module acsf_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    input  wire logic                  conv_done,
    input  wire acsf_pkg::acsf_exceed_s exceed,
    output logic [15:0]                alert_out,
    output logic                       irq,
    input  wire logic [9:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [9:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready
);
    // count registers per kind: 3 overcurrent, 2 undercurrent,
    // 1 overpower, 0 high voltage
    logic [3:0][7:0] count_reg;
    logic [3:0][7:0] next_count_reg;
    logic [23:0]     enable_reg;
    logic [23:0]     next_enable_reg;
    logic [23:0]     enable_active;
    logic [23:0]     next_enable_active;
    logic [15:0]     mask_reg;
    logic [15:0]     next_mask_reg;
    logic [15:0]     status;
    logic [15:0]     status_clr;
    logic [15:0]     qual_flat;
    logic [15:0]     gated;
    logic [15:0]     next_alert_out;
    logic [15:0]     exceed_flat;

    // write channel state
    logic            aw_full;
    logic            w_full;
    logic [7:0]      aw_idx;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            next_aw_full;
    logic            next_w_full;
    logic [7:0]      next_aw_idx;
    logic [31:0]     next_w_data;
    logic [3:0]      next_w_strb;
    logic            next_awready;
    logic            next_wready;
    logic            next_bvalid;
    logic [1:0]      next_bresp;
    logic            do_write;
    logic            refresh;
    // read channel state
    logic            next_arready;
    logic            next_rvalid;
    logic [31:0]     next_rdata;
    logic [1:0]      next_rresp;
    logic [7:0]      ar_idx;

    assign exceed_flat = exceed;

    // sixteen filters, one per kind and channel
    for (genvar k = 0; k < acsf_pkg::NUM_KIND; k++) begin : g_kind
        for (genvar c = 0; c < acsf_pkg::NUM_CH; c++) begin : g_ch
            // channel 1 in the msb field
            // and in the msb of each nibble, matching the enable layout
            localparam int POS = acsf_pkg::NUM_CH - 1 - c;
            acsf_qualify u_qual (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .ce        (ce),
                .sample    (conv_done),
                .exceed    (exceed_flat[k*acsf_pkg::NUM_CH + POS]),
                .code      (count_reg[k][POS*acsf_pkg::FIELD_W +:
                                         acsf_pkg::FIELD_W]),
                .qualified (qual_flat[k*acsf_pkg::NUM_CH + POS])
            );
        end
    end

    // enables rearranged into the status layout
    always_comb begin
        gated = qual_flat & {enable_active[acsf_pkg::EN_OC_LSB +: 4],
                             enable_active[acsf_pkg::EN_UC_LSB +: 4],
                             enable_active[acsf_pkg::EN_OP_LSB +: 4],
                             enable_active[acsf_pkg::EN_HV_LSB +: 4]};
        next_alert_out = gated;
    end

    acsf_irq u_irq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .set     (gated & ~alert_out),
        .clr     (status_clr),
        .mask    (mask_reg),
        .status  (status),
        .irq     (irq)
    );

    // write path: address and data taken in either order
    always_comb begin
        next_aw_full    = aw_full;
        next_w_full     = w_full;
        next_aw_idx     = aw_idx;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_bvalid     = bvalid;
        next_bresp      = bresp;
        next_count_reg  = count_reg;
        next_enable_reg = enable_reg;
        next_mask_reg   = mask_reg;
        status_clr      = 16'h0000;
        refresh         = 1'b0;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_idx  = awaddr[acsf_pkg::IDX_LSB +: 8];
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        do_write = aw_full && w_full && !bvalid;
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = acsf_pkg::RESP_OKAY;
            if (aw_idx == acsf_pkg::IDX_OC_COUNT) begin
                if (w_strb[0]) next_count_reg[3] = w_data[7:0];
            end else if (aw_idx == acsf_pkg::IDX_UC_COUNT) begin
                if (w_strb[0]) next_count_reg[2] = w_data[7:0];
            end else if (aw_idx == acsf_pkg::IDX_OP_COUNT) begin
                if (w_strb[0]) next_count_reg[1] = w_data[7:0];
            end else if (aw_idx == acsf_pkg::IDX_HV_COUNT) begin
                if (w_strb[0]) next_count_reg[0] = w_data[7:0];
            end else if (aw_idx == acsf_pkg::IDX_ENABLE) begin
                for (int b = 0; b < 3; b++) begin
                    if (w_strb[b]) next_enable_reg[b*8 +: 8] = w_data[b*8 +: 8];
                end
            end else if (aw_idx == acsf_pkg::IDX_REFRESH) begin
                refresh = 1'b1;
            end else if (aw_idx == acsf_pkg::IDX_STATUS) begin
                status_clr = w_data[15:0] & {{8{w_strb[1]}}, {8{w_strb[0]}}};
            end else if (aw_idx == acsf_pkg::IDX_MASK) begin
                for (int b = 0; b < 2; b++) begin
                    if (w_strb[b]) next_mask_reg[b*8 +: 8] = w_data[b*8 +: 8];
                end
            end else begin
                next_bresp = acsf_pkg::RESP_SLVERR;
            end
        end
        next_awready = !next_aw_full;
        next_wready  = !next_w_full;
        // staged enables go live on refresh; a live alert would glitch otherwise
        next_enable_active = refresh ? enable_reg : enable_active;
    end

    // read path: one cycle from address to data
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        ar_idx      = araddr[acsf_pkg::IDX_LSB +: 8];
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = acsf_pkg::RESP_OKAY;
            next_rdata  = 32'h00000000;
            if (ar_idx == acsf_pkg::IDX_OC_COUNT) begin
                next_rdata[7:0] = count_reg[3];
            end else if (ar_idx == acsf_pkg::IDX_UC_COUNT) begin
                next_rdata[7:0] = count_reg[2];
            end else if (ar_idx == acsf_pkg::IDX_OP_COUNT) begin
                next_rdata[7:0] = count_reg[1];
            end else if (ar_idx == acsf_pkg::IDX_HV_COUNT) begin
                next_rdata[7:0] = count_reg[0];
            end else if (ar_idx == acsf_pkg::IDX_ENABLE) begin
                next_rdata[23:0] = enable_reg;
            end else if (ar_idx == acsf_pkg::IDX_REFRESH) begin
                next_rdata[23:0] = enable_active;
            end else if (ar_idx == acsf_pkg::IDX_STATUS) begin
                next_rdata[15:0] = status;
            end else if (ar_idx == acsf_pkg::IDX_MASK) begin
                next_rdata[15:0] = mask_reg;
            end else begin
                next_rresp = acsf_pkg::RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg     <= {4{acsf_pkg::COUNT_RESET}};
            enable_reg    <= acsf_pkg::ENABLE_RESET;
            enable_active <= acsf_pkg::ENABLE_RESET;
            mask_reg      <= acsf_pkg::MASK_RESET;
            alert_out     <= 16'h0000;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_idx        <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            awready       <= 1'b0;
            wready        <= 1'b0;
            bvalid        <= 1'b0;
            bresp         <= acsf_pkg::RESP_OKAY;
            arready       <= 1'b0;
            rvalid        <= 1'b0;
            rdata         <= 32'h00000000;
            rresp         <= acsf_pkg::RESP_OKAY;
        end else if (ce) begin
            count_reg     <= next_count_reg;
            enable_reg    <= next_enable_reg;
            enable_active <= next_enable_active;
            mask_reg      <= next_mask_reg;
            alert_out     <= next_alert_out;
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            aw_idx        <= next_aw_idx;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            awready       <= next_awready;
            wready        <= next_wready;
            bvalid        <= next_bvalid;
            bresp         <= next_bresp;
            arready       <= next_arready;
            rvalid        <= next_rvalid;
            rdata         <= next_rdata;
            rresp         <= next_rresp;
        end
    end

    reset_counts_a: assert property (@(posedge aclk)
        !aresetn |=> count_reg == {4{acsf_pkg::COUNT_RESET}})
        else $error("count fields not cleared by reset");
    alert_gated_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce |=> (alert_out & ~$past(qual_flat)) == 16'h0000)
        else $error("alert pin without a qualified condition");
    enable_refresh_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && !refresh) |=> $stable(enable_active))
        else $error("live enables changed without refresh");
    refresh_load_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && refresh) |=> enable_active == $past(enable_reg))
        else $error("refresh did not load enables");
    one_sample_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && conv_done && count_reg[1][7:6] == acsf_pkg::CODE_1
         && exceed_flat[7] && $stable(count_reg)) |=> qual_flat[7])
        else $error("code 0 overpower ch1 not raised on one sample");
    uc_one_sample_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && conv_done && count_reg[2][5:4] == acsf_pkg::CODE_1
         && exceed_flat[10] && $stable(count_reg)) |=> qual_flat[10])
        else $error("code 0 undercurrent ch2 not raised on one sample");
    hv_one_sample_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && conv_done && count_reg[0][1:0] == acsf_pkg::CODE_1
         && exceed_flat[0] && $stable(count_reg)) |=> qual_flat[0])
        else $error("code 0 high-voltage ch4 not raised on one sample");
    read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && arvalid && arready) |=> rvalid)
        else $error("read response missing");
    // irq is built from the next status, so it never lags the status bit
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> irq == |(status & $past(mask_reg)))
        else $error("interrupt level does not follow status and mask");
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && do_write) |=> bvalid)
        else $error("write response missing");
endmodule : acsf_top

// ---- tb/acsf_top_tb.sv ----
/*
 * acsf_top_tb: self-checking bench for the alert sample filter block.
 * Assumes acsf_pkg and acsf_top are compiled first; ce is held high.
 */
`timescale 1ns/1ps
module acsf_top_tb;
    localparam logic [31:0] EN_ALL = (32'hf << acsf_pkg::EN_OC_LSB)
        | (32'hf << acsf_pkg::EN_UC_LSB) | (32'hf << acsf_pkg::EN_HV_LSB)
        | (32'hf << acsf_pkg::EN_OP_LSB);

    logic                   aclk;
    logic                   aresetn;
    logic                   ce;
    logic                   conv_done;
    acsf_pkg::acsf_exceed_s exceed;
    logic [15:0]            alert_out;
    logic                   irq;
    logic [9:0]             awaddr;
    logic                   awvalid;
    logic                   awready;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   wready;
    logic [1:0]             bresp;
    logic                   bvalid;
    logic                   bready;
    logic [9:0]             araddr;
    logic                   arvalid;
    logic                   arready;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   rvalid;
    logic                   rready;
    int                     num_errors;
    int                     total_checks;
    logic [1:0]             resp;
    logic [31:0]            rd;
    logic [7:0]             cnt_idx [4];

    acsf_top dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .conv_done(conv_done),
        .exceed(exceed), .alert_out(alert_out), .irq(irq),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task give_verdict;
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // address and data offered together, each dropped once taken
    task axi_wr(input logic [7:0] idx, input logic [31:0] d);
        int   t;
        logic aw_ok;
        logic w_ok;
        logic fin;
        t = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        fin = 1'b0;
        @(posedge aclk);
        awaddr  <= {idx, 2'h0};
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!fin && t < 100) begin
            @(posedge aclk);
            t++;
            if (aw_ok && w_ok && bvalid) begin
                resp = bresp;
                fin = 1'b1;
            end
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        if (!fin) begin
            num_errors++;
            give_verdict();
        end
    endtask : axi_wr

    task axi_rd(input logic [7:0] idx);
        int   t;
        logic ar_ok;
        logic fin;
        t = 0;
        ar_ok = 1'b0;
        fin = 1'b0;
        @(posedge aclk);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!fin && t < 100) begin
            @(posedge aclk);
            t++;
            if (ar_ok && rvalid) begin
                rd = rdata;
                resp = rresp;
                fin = 1'b1;
            end
            if (!ar_ok && arready) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        if (!fin) begin
            num_errors++;
            give_verdict();
        end
    endtask : axi_rd

    // one conversion, then wait out alert, status and irq latency
    task conv(input logic [15:0] ex);
        @(posedge aclk);
        conv_done <= 1'b1;
        exceed    <= ex;
        @(posedge aclk);
        conv_done <= 1'b0;
        exceed    <= 16'h0000;
        repeat (3) @(posedge aclk);
        #1;
    endtask : conv

    task settle;
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle

    // a broken run must restart, so the run is tried twice with a gap
    task run(input int k, input int c);
        logic [1:0]  code;
        int          n;
        int          pos;
        logic [15:0] bitv;
        code = 2'((k + c) % 4);
        n = (code == 2'h0) ? 1 : (4 << (int'(code) - 1));
        pos = (4 - c) * 2;
        bitv = 16'h1 << ((3 - k) * 4 + 4 - c);
        axi_wr(acsf_pkg::IDX_ENABLE, 32'h0);
        axi_wr(acsf_pkg::IDX_REFRESH, 32'h0);
        axi_wr(cnt_idx[k], 32'(code) << pos);
        axi_rd(cnt_idx[k]);
        chk("count field", rd, 32'(code) << pos);
        axi_wr(acsf_pkg::IDX_ENABLE, EN_ALL);
        axi_wr(acsf_pkg::IDX_REFRESH, 32'h0);
        for (int r = 0; r < 2; r++) begin
            for (int i = 1; i < n; i++) begin
                conv(bitv);
                chk("alert early", {16'h0, alert_out}, 32'h0);
            end
            if (r == 0)
                conv(16'h0000);
        end
        repeat (5) @(posedge aclk);
        conv(bitv);
        chk("alert at run", {16'h0, alert_out}, {16'h0, bitv});
        conv(bitv);
        chk("alert held", {16'h0, alert_out}, {16'h0, bitv});
        conv(16'h0000);
        chk("alert cleared", {16'h0, alert_out}, 32'h0);
    endtask : run

    initial begin
        #(25 * 60000);
        num_errors++;
        give_verdict();
    end

    initial begin
        num_errors = 0;
        total_checks = 0;
        ce = 1'b1;
        aresetn = 1'b0;
        conv_done = 1'b0;
        exceed = 16'h0000;
        awaddr = 10'h000;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 10'h000;
        arvalid = 1'b0;
        rready = 1'b0;
        cnt_idx = '{acsf_pkg::IDX_OC_COUNT, acsf_pkg::IDX_UC_COUNT,
                    acsf_pkg::IDX_OP_COUNT, acsf_pkg::IDX_HV_COUNT};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            axi_rd(cnt_idx[k]);
            chk("count reset", rd, 32'h0);
        end
        // undervoltage count is not implemented, so its slot is unmapped
        axi_rd(8'h48);
        chk("unmapped rresp", {30'h0, resp}, {30'h0, acsf_pkg::RESP_SLVERR});
        chk("unmapped rdata", rd, 32'h0);
        axi_wr(8'h48, 32'hffffffff);
        chk("unmapped bresp", {30'h0, resp}, {30'h0, acsf_pkg::RESP_SLVERR});
        axi_wr(acsf_pkg::IDX_ENABLE, EN_ALL);
        conv(16'hffff);
        chk("alert unrefreshed", {16'h0, alert_out}, 32'h0);
        axi_wr(acsf_pkg::IDX_REFRESH, 32'h0);
        axi_rd(acsf_pkg::IDX_REFRESH);
        chk("live enables", rd, EN_ALL);
        conv(16'hffff);
        chk("alert refreshed", {16'h0, alert_out}, 32'hffff);
        conv(16'h0000);
        axi_rd(acsf_pkg::IDX_STATUS);
        chk("status set", rd, 32'hffff);
        chk("irq masked", {31'h0, irq}, 32'h0);
        axi_wr(acsf_pkg::IDX_STATUS, 32'hffff);
        axi_rd(acsf_pkg::IDX_STATUS);
        chk("status cleared", rd, 32'h0);
        axi_wr(acsf_pkg::IDX_MASK, 32'h8000);
        conv(16'h8000);
        chk("irq raised", {31'h0, irq}, 32'h1);
        axi_wr(acsf_pkg::IDX_MASK, 32'h0);
        settle();
        chk("irq unmasked off", {31'h0, irq}, 32'h0);
        axi_wr(acsf_pkg::IDX_MASK, 32'h8000);
        conv(16'h0000);
        chk("irq sticky", {31'h0, irq}, 32'h1);
        axi_wr(acsf_pkg::IDX_STATUS, 32'h8000);
        settle();
        chk("irq cleared", {31'h0, irq}, 32'h0);
        axi_wr(acsf_pkg::IDX_MASK, 32'h0);
        for (int k = 0; k < 4; k++)
            for (int c = 1; c <= 4; c++)
                run(k, c);
        give_verdict();
    end
endmodule : acsf_top_tb
